// ==== rtl/lc_cfg_mem.v ====
// configuration store: one word per logic cell, all words read from registers
module lc_cfg_mem #(
  parameter WIDTH = 46,
  parameter DEPTH = 10,
  parameter AW = 4
) (
  input wire core_clk,
  input wire rst_n,
  input wire clk_en,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  output wire [WIDTH*DEPTH-1:0] rd_flat
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  integer k;
  genvar g;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (k = 0; k < DEPTH; k = k + 1) begin
        mem[k] <= {WIDTH{1'b0}};
      end
    end else if (clk_en && wr_en && (wr_addr < DEPTH)) begin
      mem[wr_addr] <= wr_data;
    end
  end

  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : rd
      assign rd_flat[g*WIDTH +: WIDTH] = mem[g];
    end
  endgenerate
endmodule

// ==== rtl/lc_cluster.v ====
// logic cluster: ten logic cells, local interconnect, chains, cluster controls
//
// Contract
// - ten logic cells share interconnect and controls
// - 26 external inputs plus ten feedback lines
// - lut cascade feeds next cell directly
// - register cascade builds shift chains
// - routing, own outputs, side links drive interconnect
// - each output reaches thirty cells
// - eight cluster controls: gates, clears, loads, addsub
// - each clock tied to its own gate
// - clock one uses rising edges, clock two rising or falling
// - deasserted gate stops its cluster clock
// - preset via async load with data one
// - addsub selects one-bit add or subtract
// - controls from column clocks or local lines
// - four global lines carry clocks or controls
// - subtract inverts b, forces carry-in one
// - sync clear and load hit all registers
`include "lc_cluster_map.vh"
module lc_cluster #(
  parameter CELLS = `LC_CELLS,
  parameter EXT = `LC_EXT_IN,
  parameter CFG_W = `LC_CFG_W
) (
  input wire core_clk,
  input wire rst_n,
  input wire clk_en,
  input wire [`LC_GLOBALS-1:0] col_clk,
  input wire [`LC_ROUTE_IN-1:0] row_column_routing,
  input wire [`LC_LINK_IN-1:0] side_neighbour_link_left,
  input wire [`LC_LINK_IN-1:0] side_neighbour_link_right,
  input wire reg_chain_in,
  input wire [EXT*`LC_SEL_W-1:0] ext_sel,
  input wire [1:0] clk_one_sel,
  input wire [1:0] clk_two_sel,
  input wire clk_two_falling,
  input wire [`LC_CTL_N-1:0] ctl_use,
  input wire [`LC_CTL_N*`LC_SEL_W-1:0] ctl_sel,
  input wire cfg_wr_en,
  input wire [3:0] cfg_wr_addr,
  input wire [CFG_W-1:0] cfg_wr_data,
  output reg [CELLS-1:0] cell_out,
  output reg [CELLS-1:0] link_out_left,
  output reg [CELLS-1:0] link_out_right,
  output reg reg_chain_out,
  output reg carry_out,
  output reg [`LC_CTL_N-1:0] ctl_active
);
  // one bit out of a zero-padded source vector
  function pick;
    input [63:0] vec;
    input [5:0] idx;
    begin
      pick = vec[idx];
    end
  endfunction

  // edge of a selected column clock
  function clk_edge;
    input [3:0] now;
    input [3:0] prev;
    input [1:0] sel;
    input falling;
    begin
      if (falling) begin
        clk_edge = prev[sel] & ~now[sel];
      end else begin
        clk_edge = now[sel] & ~prev[sel];
      end
    end
  endfunction

  wire [CFG_W*CELLS-1:0] cfg_flat;
  reg [CELLS-1:0] q;
  reg [`LC_GLOBALS-1:0] col_prev;
  reg [CELLS-1:0] next_q;
  reg [CELLS-1:0] next_out;
  reg [CELLS-1:0] lut;
  reg [CELLS:0] carry;
  reg [EXT-1:0] ext_line;
  reg [`LC_CTL_N-1:0] ctl;
  reg [63:0] ext_src;
  reg [63:0] lcl_src;
  reg ev_one;
  reg ev_two;
  reg [CFG_W-1:0] w;
  reg [3:0] d;
  reg b_eff;
  reg dreg;
  reg ev;
  reg clr;
  integer i;
  integer k;
  localparam [`LC_CTL_N-1:0] CTL_IDLE = `LC_CTL_IDLE;

  // per-cell configuration for the ten cells
  lc_cfg_mem #(
    .WIDTH(CFG_W),
    .DEPTH(CELLS),
    .AW(4)
  ) u_cfg (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .wr_en(cfg_wr_en),
    .wr_addr(cfg_wr_addr),
    .wr_data(cfg_wr_data),
    .rd_flat(cfg_flat)
  );

  always @* begin
    // routing and both side links feed the slots
    ext_src = {18'h0, side_neighbour_link_right, side_neighbour_link_left, row_column_routing};
    for (k = 0; k < EXT; k = k + 1) begin
      ext_line[k] = pick(ext_src, ext_sel[k*`LC_SEL_W +: `LC_SEL_W]);
    end
    // ten feedback lines after the slots
    // global lines usable as control sources
    lcl_src = {24'h0, col_clk, cell_out, ext_line};
    // controls from local lines or column clocks
    for (k = 0; k < `LC_CTL_N; k = k + 1) begin
      if (ctl_use[k]) begin
        ctl[k] = pick(lcl_src, ctl_sel[k*`LC_SEL_W +: `LC_SEL_W]);
      end else begin
        ctl[k] = CTL_IDLE[k];
      end
    end
    // clock two may follow the falling edge
    ev_one = clk_edge(col_clk, col_prev, clk_one_sel, 1'b0);
    ev_two = clk_edge(col_clk, col_prev, clk_two_sel, clk_two_falling);
    // subtract forces carry-in one at the first cell
    carry[0] = ctl[`LC_CTL_ADDSUB];
    next_q = q;
    next_out = cell_out;
    lut = {CELLS{1'b0}};
    w = {CFG_W{1'b0}};
    d = 4'h0;
    b_eff = 1'b0;
    dreg = 1'b0;
    ev = 1'b0;
    clr = 1'b0;
    for (i = 0; i < CELLS; i = i + 1) begin
      w = cfg_flat[i*CFG_W +: CFG_W];
      d[0] = pick(lcl_src, w[`LC_F_D0 +: `LC_SEL_W]);
      d[1] = pick(lcl_src, w[`LC_F_D1 +: `LC_SEL_W]);
      d[2] = pick(lcl_src, w[`LC_F_D2 +: `LC_SEL_W]);
      d[3] = pick(lcl_src, w[`LC_F_D3 +: `LC_SEL_W]);
      if (w[`LC_F_LUT_CHAIN]) begin
        d[0] = (i == 0) ? 1'b0 : lut[(i == 0) ? 0 : i-1];
      end
      // one-bit add or subtract per cell
      b_eff = d[1] ^ ctl[`LC_CTL_ADDSUB];
      if (w[`LC_F_ARITH]) begin
        lut[i] = d[0] ^ b_eff ^ carry[i];
        carry[i+1] = (d[0] & b_eff) | (carry[i] & (d[0] ^ b_eff));
      end else begin
        lut[i] = w[`LC_F_MASK + d];
        carry[i+1] = 1'b0;
      end
      // register fed by previous cell's register
      if (w[`LC_F_REG_CHAIN]) begin
        dreg = (i == 0) ? reg_chain_in : q[(i == 0) ? 0 : i-1];
      end else begin
        dreg = lut[i];
      end
      // clock choice carries its paired gate
      if (w[`LC_F_CLK_TWO]) begin
        ev = ev_two & ctl[`LC_CTL_GATE_TWO];
      end else begin
        ev = ev_one & ctl[`LC_CTL_GATE_ONE];
      end
      clr = w[`LC_F_ACLR_TWO] ? ctl[`LC_CTL_ACLR_TWO] : ctl[`LC_CTL_ACLR_ONE];
      // async clear first, then async load
      if (clr) begin
        next_q[i] = 1'b0;
      end else if (ctl[`LC_CTL_ALOAD]) begin
        // load data from data3, high gives preset
        next_q[i] = d[3];
      end else if (ev) begin
        // shared sync clear and load on every register
        if (ctl[`LC_CTL_SCLR]) begin
          next_q[i] = 1'b0;
        end else if (ctl[`LC_CTL_SLOAD]) begin
          next_q[i] = d[3];
        end else begin
          next_q[i] = dreg;
        end
      end
      next_out[i] = w[`LC_F_OUT_REG] ? next_q[i] : lut[i];
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= {CELLS{1'b0}};
      col_prev <= {`LC_GLOBALS{1'b0}};
      cell_out <= {CELLS{1'b0}};
      link_out_left <= {CELLS{1'b0}};
      link_out_right <= {CELLS{1'b0}};
      reg_chain_out <= 1'b0;
      carry_out <= 1'b0;
      ctl_active <= {`LC_CTL_N{1'b0}};
    end else if (clk_en) begin
      q <= next_q;
      col_prev <= col_clk;
      cell_out <= next_out;
      // outputs also go left and right: 10+10+10 cells
      link_out_left <= next_out;
      link_out_right <= next_out;
      reg_chain_out <= next_q[CELLS-1];
      carry_out <= carry[CELLS];
      // at most eight controls, seen as registered values one cycle later
      ctl_active <= ctl;
    end
  end
endmodule

// ==== rtl/lc_cluster_map.vh ====
// constants for the logic cluster: sizes, config word layout, control slots
`ifndef LC_CLUSTER_MAP_VH
`define LC_CLUSTER_MAP_VH
`define LC_CELLS 10
`define LC_EXT_IN 26
`define LC_ROUTE_IN 26
`define LC_LINK_IN 10
`define LC_LOCAL 36
`define LC_GLOBALS 4
`define LC_SEL_W 6
// source numbering for the 26 external slots
`define LC_SRC_ROUTE 0
`define LC_SRC_LEFT 26
`define LC_SRC_RIGHT 36
// source numbering on the local bus (36 local lines plus global lines)
`define LC_SRC_EXT 0
`define LC_SRC_FEEDBACK 26
`define LC_SRC_GLOBAL 36
// per-cell configuration word
`define LC_CFG_W 46
`define LC_F_MASK 0
`define LC_F_D0 16
`define LC_F_D1 22
`define LC_F_D2 28
`define LC_F_D3 34
`define LC_F_CLK_TWO 40
`define LC_F_ACLR_TWO 41
`define LC_F_ARITH 42
`define LC_F_LUT_CHAIN 43
`define LC_F_REG_CHAIN 44
`define LC_F_OUT_REG 45
`define LC_CFG_RESET 46'h0
// cluster control slots
`define LC_CTL_N 8
`define LC_CTL_GATE_ONE 0
`define LC_CTL_GATE_TWO 1
`define LC_CTL_ACLR_ONE 2
`define LC_CTL_ACLR_TWO 3
`define LC_CTL_SCLR 4
`define LC_CTL_ALOAD 5
`define LC_CTL_SLOAD 6
`define LC_CTL_ADDSUB 7
`define LC_CTL_IDLE 8'h03
`endif

// ==== tb/lc_cluster_chk.sv ====
// port assertions for the logic cluster
module lc_cluster_chk (
  input wire core_clk,
  input wire rst_n,
  input wire clk_en,
  input wire [3:0] col_clk,
  input wire [7:0] ctl_use,
  input wire [47:0] ctl_sel,
  input wire [9:0] cell_out,
  input wire [9:0] link_out_left,
  input wire [9:0] link_out_right,
  input wire [7:0] ctl_active
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [7:0] csel;
  integer k;
  // column line picked by each slot
  always @(posedge core_clk) begin
    for (k = 0; k < 8; k = k + 1) begin
      csel[k] <= col_clk[ctl_sel[6*k +: 2]];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  link_copy_a: assert property (link_out_left == cell_out && link_out_right == cell_out)
    else $error("link copy differs");
  ctl_idle_a: assert property (clk_en && ctl_use == 8'h00 |=> ctl_active == 8'h03)
    else $error("idle controls wrong");
  gate_line_a: assert property (clk_en && ctl_use[0] && ctl_sel[5:2] == 4'h9 |=> ctl_active[0] == csel[0])
    else $error("gate one not from line");
  clear_line_a: assert property (clk_en && ctl_use[2] && ctl_sel[17:14] == 4'h9 ##1 1 |-> ctl_active[2] == csel[2])
    else $error("clear one not from line");
  load_line_a: assert property (clk_en && ctl_use[5] && ctl_sel[35:32] == 4'h9 |=> ctl_active[5] == csel[5])
    else $error("async load not from line");
  addsub_line_a: assert property (clk_en && ctl_use[7] && ctl_sel[47:44] == 4'h9 |=> ctl_active[7] == csel[7])
    else $error("addsub not from line");
  freeze_hold_a: assert property (!clk_en |=> $stable(cell_out) && $stable(ctl_active))
    else $error("state moved while frozen");
  reset_zero_a: assert property ($rose(rst_n) |-> cell_out == 10'h000 && ctl_active == 8'h00)
    else $error("outputs not cleared");
endmodule
bind lc_cluster lc_cluster_chk u_lc_cluster_chk (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
  .col_clk(col_clk), .ctl_use(ctl_use), .ctl_sel(ctl_sel), .cell_out(cell_out),
  .link_out_left(link_out_left), .link_out_right(link_out_right), .ctl_active(ctl_active));

// ==== tb/lc_far_side.sv ====
// global clock network model driving the column lines
module lc_far_side (
  input wire core_clk,
  input wire rst_n,
  input wire [3:0] run,
  input wire [3:0] hold,
  output reg [3:0] col_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      col_clk <= 4'h0;
    end else begin
      col_clk <= (run & ~col_clk) | (~run & hold);
    end
  end
endmodule

// ==== tb/test_lc_cluster.sv ====
// self-checking bench for the logic cluster
module test_lc_cluster;
  timeunit 1ns;
  timeprecision 1ps;
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  reg clk_en = 1'b1;
  reg [3:0] run = 4'h0;
  reg [3:0] hold = 4'h0;
  reg two_falling = 1'b0;
  reg [25:0] route = 26'h0;
  reg [9:0] left = 10'h1;
  reg [155:0] ext_sel;
  reg [7:0] ctl_use = 8'h00;
  reg [47:0] ctl_sel = 48'h0;
  reg cfg_wr_en = 1'b0;
  reg [3:0] cfg_wr_addr = 4'h0;
  reg [45:0] cfg_wr_data = 46'h0;
  wire [3:0] col_clk;
  wire [9:0] cell_out;
  wire chain_out;
  wire carry_out;
  wire [7:0] ctl_active;
  integer n_mismatch = 0;
  integer checks = 0;
  integer i;
  always #2.5 core_clk = ~core_clk;
  lc_far_side u_lc_far_side (.core_clk(core_clk), .rst_n(rst_n), .run(run), .hold(hold), .col_clk(col_clk));
  lc_cluster u_lc_cluster (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .col_clk(col_clk),
    .row_column_routing(route), .side_neighbour_link_left(left), .side_neighbour_link_right(10'h0),
    .reg_chain_in(1'b1), .ext_sel(ext_sel), .clk_one_sel(2'h0), .clk_two_sel(2'h0), .clk_two_falling(two_falling),
    .ctl_use(ctl_use), .ctl_sel(ctl_sel), .cfg_wr_en(cfg_wr_en), .cfg_wr_addr(cfg_wr_addr),
    .cfg_wr_data(cfg_wr_data), .cell_out(cell_out), .link_out_left(), .link_out_right(),
    .reg_chain_out(chain_out), .carry_out(carry_out), .ctl_active(ctl_active));
  task chk(input string nm, input [9:0] exp, input [9:0] got);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) begin
      @(posedge core_clk);
      cfg_wr_en <= 1'b0;
    end
  endtask
  task cfg(input [3:0] a, input [45:0] d);
    begin
      @(posedge core_clk);
      cfg_wr_en <= 1'b1;
      cfg_wr_addr <= a;
      cfg_wr_data <= d;
    end
  endtask
  function [45:0] cw(input [5:0] f, input [5:0] d1, input [5:0] d0, input [15:0] m);
    cw = {f, 12'h0, d1, d0, m};
  endfunction
  task pulses;
    begin
      run <= 4'h1;
      tick(6);
      run <= 4'h0;
      tick(3);
    end
  endtask
  task t_routes;
    begin
      cfg(4'h0, cw(6'h00, 6'h0, 6'h00, 16'hAAAA));
      cfg(4'h1, cw(6'h08, 6'h0, 6'h00, 16'h5555));
      cfg(4'h2, cw(6'h00, 6'h0, 6'h18, 16'hAAAA));
      cfg(4'h3, cw(6'h00, 6'h0, 6'h19, 16'hAAAA));
      cfg(4'h4, cw(6'h00, 6'h0, 6'h1A, 16'hAAAA));
      route <= 26'h1;
      tick(4);
      chk("cell_out", 10'h015, cell_out & 10'h01F);
    end
  endtask
  task t_arith(input as, input [3:0] exp);
    begin
      for (i = 0; i < 4; i = i + 1) begin
        cfg(i[3:0], cw(6'h04, i[5:0] + 6'h4, i[5:0], 16'h0));
      end
      ctl_use <= 8'h80;
      ctl_sel <= 48'h940000000000;
      hold <= {2'h0, as, 1'b0};
      route <= 26'h35;
      tick(4);
      chk("cell_out", {6'h0, exp}, cell_out & 10'h00F);
    end
  endtask
  task t_carry;
    begin
      for (i = 0; i < 10; i = i + 1) begin
        cfg(i[3:0], cw(6'h04, 6'h19, 6'h18, 16'h0));
      end
      ctl_use <= 8'h80;
      ctl_sel <= 48'h940000000000;
      hold <= 4'h2;
      tick(4);
      // 3FF minus zero: sum 3FF, no borrow so carry out high
      chk("cell_out", 10'h3FF, cell_out);
      chk("carry_out", 10'h001, {9'h0, carry_out});
      hold <= 4'h0;
      tick(3);
      chk("carry_out", 10'h000, {9'h0, carry_out});
    end
  endtask
  task t_shift;
    begin
      for (i = 0; i < 10; i = i + 1) begin
        cfg(i[3:0], cw(6'h30, 6'h0, 6'h0, 16'h0));
      end
      ctl_use <= 8'h00;
      tick(2);
      pulses;
      chk("cell_out", 10'h007, cell_out);
      ctl_use <= 8'h01;
      ctl_sel <= 48'h26;
      pulses;
      chk("cell_out", 10'h007, cell_out);
      clk_en <= 1'b0;
      ctl_use <= 8'h00;
      pulses;
      // frozen cluster ignores the column clock
      chk("cell_out", 10'h007, cell_out);
      clk_en <= 1'b1;
      pulses;
      chk("cell_out", 10'h03F, cell_out);
      hold <= 4'h8;
      ctl_sel <= 48'h9C0027000;
      ctl_use <= 8'h24;
      tick(3);
      chk("cell_out", 10'h000, cell_out);
      ctl_use <= 8'h20;
      tick(3);
      chk("cell_out", 10'h3FF, cell_out);
      chk("reg_chain_out", {9'h0, 1'b1}, {9'h0, chain_out});
    end
  endtask
  task t_sync;
    begin
      ctl_sel <= 48'h027027000000;
      ctl_use <= 8'h10;
      tick(3);
      // no cluster clock edge yet, so sync clear waits
      chk("cell_out", 10'h3FF, cell_out);
      pulses;
      chk("cell_out", 10'h000, cell_out);
      ctl_use <= 8'h40;
      pulses;
      chk("cell_out", 10'h3FF, cell_out);
    end
  endtask
  task t_edges;
    begin
      for (i = 0; i < 10; i = i + 1) begin
        cfg(i[3:0], cw((i < 5) ? 6'h20 : 6'h23, 6'h0, 6'h0, 16'hFFFF));
      end
      ctl_sel <= 48'h9C0980;
      ctl_use <= 8'h08;
      two_falling <= 1'b1;
      tick(3);
      chk("cell_out", 10'h01F, cell_out);
      ctl_use <= 8'h00;
      hold <= 4'h9;
      tick(3);
      chk("cell_out", 10'h01F, cell_out);
      hold <= 4'h8;
      tick(3);
      chk("cell_out", 10'h3FF, cell_out);
      ctl_use <= 8'h08;
      tick(3);
      ctl_use <= 8'h02;
      hold <= 4'h9;
      tick(3);
      hold <= 4'h8;
      tick(3);
      chk("cell_out", 10'h01F, cell_out);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  initial begin
    for (i = 0; i < 24; i = i + 1) begin
      ext_sel[6*i +: 6] <= i[5:0];
    end
    ext_sel[155:144] <= 12'h91A;
    tick(8);
    rst_n <= 1'b1;
    t_routes;
    t_arith(1'b0, 4'h8);
    t_arith(1'b1, 4'h2);
    t_carry;
    t_shift;
    t_sync;
    t_edges;
    print_verdict;
  end
endmodule
